//--- design/ctpg_consts.svh
`ifndef CTPG_CONSTS_SVH
`define CTPG_CONSTS_SVH
// register map, byte wide registers on the pattern page
`define CTPG_ADDR_CTL       8'h01
`define CTPG_ADDR_CFG       8'h02
`define CTPG_ADDR_DI        8'h03
`define CTPG_ADDR_LSIZE1    8'h04
`define CTPG_ADDR_LSIZE0    8'h05
`define CTPG_ADDR_BSIZE1    8'h06
`define CTPG_ADDR_BSIZE0    8'h07
`define CTPG_ADDR_ACT1      8'h08
`define CTPG_ADDR_ACT0      8'h09
`define CTPG_ADDR_TOT1      8'h0a
`define CTPG_ADDR_TOT0      8'h0b
`define CTPG_ADDR_PD1       8'h0c
`define CTPG_ADDR_PD0       8'h0d
`define CTPG_ADDR_VBP       8'h0e
`define CTPG_ADDR_VFP       8'h0f
`define CTPG_ADDR_STAT      8'h10
`define CTPG_ADDR_FBLK      8'h11
`define CTPG_ADDR_FIX0      8'h20
// field positions
`define CTPG_CTL_EN_BIT     0
`define CTPG_CFG_FIXED_BIT  7
`define CTPG_CFG_BARS_LSB   4
`define CTPG_CFG_BARS_MSB   5
`define CTPG_FBLK_MSB       4
// csi-2 short packet codes
`define CTPG_DT_FS          6'h00
`define CTPG_DT_FE          6'h01
// reset values
`define CTPG_RST_CFG        8'h30
`define CTPG_RST_DI         8'h24
`define CTPG_RST_FBLK       5'h10
// line period unit
`define CTPG_UNIT_NS        10
`define CTPG_CLK_NS         10
`endif

//--- design/ctpg_pkg.sv
package ctpg_pkg;
	typedef enum logic [4:0] {
		CTPG_IDLE  = 5'b00001,
		CTPG_SHORT = 5'b00010,
		CTPG_HDR   = 5'b00100,
		CTPG_DATA  = 5'b01000,
		CTPG_WAIT  = 5'b10000
	} ctpg_state_t;
endpackage : ctpg_pkg

//--- design/ctpg_top.sv
// How it works
// - colour bar mode defaults to eight bars per line.
// - eight bars carry AA,33,F0,7F,55,CC,0F,80 in order, each bar-length bytes.
// - last bar stretches to fill the remaining line bytes.
// - bar count selects one, two, four or eight.
// - line length and bar length are separate programmable byte counts.
// - long packets carry programmed data type and virtual channel; short packets carry the programmed channel only.
// - active line count and total line count are programmed separately.
// - line period is programmed in 10 ns units.
// - front porch blank lines come before frame end.
// - back porch blank lines follow frame start.
// - runs on the transmit clock, emits fully formatted packets.
// - fixed mode reuses the frame and line geometry.
// - fixed mode alternates pattern and its complement per bar.
// - fixed mode repeats a block of programmable length.
// - block length up to sixteen bytes.
// - sixteen byte registers hold the fixed pattern.
// - controls sit on the pattern generator register page.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ctpg_consts.svh"
module ctpg_top #(
	parameter int NBYTE = 16
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            tx_sop,
	output logic            tx_short,
	output logic      [7:0] tx_di,
	output logic     [15:0] tx_wc,
	output logic            tx_valid,
	output logic      [7:0] tx_data,
	output logic            tx_eop,
	input  wire logic       tx_ready
);
	import ctpg_pkg::*;

	localparam int PD_DIV = `CTPG_UNIT_NS / `CTPG_CLK_NS; // clocks per period unit

	logic [7:0]  ctl_reg, cfg_reg, di_reg, vbp_reg, vfp_reg;
	logic [15:0] lsize_reg, bsize_reg, act_reg, tot_reg, pd_reg;
	logic [4:0]  fblk_reg;
	logic [7:0]  fix_reg [NBYTE];
	logic [7:0]  rdata_next;
	ctpg_state_t st_reg;
	logic [15:0] line_reg, byte_reg, barpos_reg, pd_cnt_reg;
	logic [2:0]  bar_reg;
	logic [3:0]  fidx_reg;
	logic        fe_reg;
	logic        en;
	logic [2:0]  bar_last;
	logic [7:0]  bar_byte;
	logic [7:0]  pix;

	// bar fill table
	function automatic logic [7:0] ctpg_bar_val(input logic [2:0] i);
		case (i)
			3'h0: ctpg_bar_val = 8'haa;
			3'h1: ctpg_bar_val = 8'h33;
			3'h2: ctpg_bar_val = 8'hf0;
			3'h3: ctpg_bar_val = 8'h7f;
			3'h4: ctpg_bar_val = 8'h55;
			3'h5: ctpg_bar_val = 8'hcc;
			3'h6: ctpg_bar_val = 8'h0f;
			default: ctpg_bar_val = 8'h80;
		endcase
	endfunction : ctpg_bar_val

	// word register write helper
	function automatic logic [15:0] ctpg_wr16(input logic [15:0] r, input logic hi,
		input logic [7:0] d);
		ctpg_wr16 = hi ? {d, r[7:0]} : {r[15:8], d};
	endfunction : ctpg_wr16

	assign en = ctl_reg[`CTPG_CTL_EN_BIT];

	// control register writes on the pattern page
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctl_reg   <= 8'h00;
			cfg_reg   <= `CTPG_RST_CFG;
			di_reg    <= `CTPG_RST_DI;
			lsize_reg <= 16'h0000;
			bsize_reg <= 16'h0000;
			act_reg   <= 16'h0000;
			tot_reg   <= 16'h0000;
			pd_reg    <= 16'h0000;
			vbp_reg   <= 8'h00;
			vfp_reg   <= 8'h00;
			fblk_reg  <= `CTPG_RST_FBLK;
		end else if (reg_wr) begin
			case (reg_addr)
				`CTPG_ADDR_CTL:    ctl_reg <= reg_wdata;
				`CTPG_ADDR_CFG:    cfg_reg <= reg_wdata;
				`CTPG_ADDR_DI:     di_reg <= reg_wdata;
				`CTPG_ADDR_LSIZE1: lsize_reg <= ctpg_wr16(lsize_reg, 1'b1, reg_wdata);
				`CTPG_ADDR_LSIZE0: lsize_reg <= ctpg_wr16(lsize_reg, 1'b0, reg_wdata);
				`CTPG_ADDR_BSIZE1: bsize_reg <= ctpg_wr16(bsize_reg, 1'b1, reg_wdata);
				`CTPG_ADDR_BSIZE0: bsize_reg <= ctpg_wr16(bsize_reg, 1'b0, reg_wdata);
				`CTPG_ADDR_ACT1:   act_reg <= ctpg_wr16(act_reg, 1'b1, reg_wdata);
				`CTPG_ADDR_ACT0:   act_reg <= ctpg_wr16(act_reg, 1'b0, reg_wdata);
				`CTPG_ADDR_TOT1:   tot_reg <= ctpg_wr16(tot_reg, 1'b1, reg_wdata);
				`CTPG_ADDR_TOT0:   tot_reg <= ctpg_wr16(tot_reg, 1'b0, reg_wdata);
				`CTPG_ADDR_PD1:    pd_reg <= ctpg_wr16(pd_reg, 1'b1, reg_wdata);
				`CTPG_ADDR_PD0:    pd_reg <= ctpg_wr16(pd_reg, 1'b0, reg_wdata);
				`CTPG_ADDR_VBP:    vbp_reg <= reg_wdata;
				`CTPG_ADDR_VFP:    vfp_reg <= reg_wdata;
				`CTPG_ADDR_FBLK: begin
					// clamp to sixteen bytes
					if (reg_wdata[7:`CTPG_FBLK_MSB] != 4'h0)
						fblk_reg <= `CTPG_RST_FBLK;
					else
						fblk_reg <= reg_wdata[`CTPG_FBLK_MSB:0];
				end
				default: ;
			endcase
		end
	end

	// fixed pattern byte registers
	genvar gi;
	generate
		for (gi = 0; gi < NBYTE; gi++) begin : g_fix
			always_ff @(posedge clk) begin
				if (sys_rst)
					fix_reg[gi] <= 8'h00;
				else if (reg_wr && reg_addr == 8'(`CTPG_ADDR_FIX0 + gi))
					fix_reg[gi] <= reg_wdata;
			end
		end
	endgenerate

	// read mux
	always_comb begin
		rdata_next = 8'h00;
		case (reg_addr)
			`CTPG_ADDR_CTL:    rdata_next = ctl_reg;
			`CTPG_ADDR_CFG:    rdata_next = cfg_reg;
			`CTPG_ADDR_DI:     rdata_next = di_reg;
			`CTPG_ADDR_LSIZE1: rdata_next = lsize_reg[15:8];
			`CTPG_ADDR_LSIZE0: rdata_next = lsize_reg[7:0];
			`CTPG_ADDR_BSIZE1: rdata_next = bsize_reg[15:8];
			`CTPG_ADDR_BSIZE0: rdata_next = bsize_reg[7:0];
			`CTPG_ADDR_ACT1:   rdata_next = act_reg[15:8];
			`CTPG_ADDR_ACT0:   rdata_next = act_reg[7:0];
			`CTPG_ADDR_TOT1:   rdata_next = tot_reg[15:8];
			`CTPG_ADDR_TOT0:   rdata_next = tot_reg[7:0];
			`CTPG_ADDR_PD1:    rdata_next = pd_reg[15:8];
			`CTPG_ADDR_PD0:    rdata_next = pd_reg[7:0];
			`CTPG_ADDR_VBP:    rdata_next = vbp_reg;
			`CTPG_ADDR_VFP:    rdata_next = vfp_reg;
			`CTPG_ADDR_STAT:   rdata_next = {2'b00, fe_reg, st_reg};
			`CTPG_ADDR_FBLK:   rdata_next = {3'b000, fblk_reg};
			default: begin
				if (reg_addr >= `CTPG_ADDR_FIX0 && reg_addr < 8'(`CTPG_ADDR_FIX0 + NBYTE))
					rdata_next = fix_reg[4'(reg_addr - `CTPG_ADDR_FIX0)];
			end
		endcase
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 8'h00;
	end

	// last bar index from the bar count field
	always_comb begin
		case (cfg_reg[`CTPG_CFG_BARS_MSB:`CTPG_CFG_BARS_LSB])
			2'h0: bar_last = 3'h0;
			2'h1: bar_last = 3'h1;
			2'h2: bar_last = 3'h3;
			default: bar_last = 3'h7;
		endcase
	end

	// colour bars spread over the table, final bar always the long one
	always_comb begin
		case (bar_last)
			3'h0: bar_byte = ctpg_bar_val(3'h7);
			3'h1: bar_byte = ctpg_bar_val({bar_reg[0], 2'b11});
			3'h3: bar_byte = ctpg_bar_val({bar_reg[1:0], 1'b1});
			default: bar_byte = ctpg_bar_val(bar_reg);
		endcase
		if (cfg_reg[`CTPG_CFG_FIXED_BIT])
			pix = bar_reg[0] ? ~fix_reg[fidx_reg] : fix_reg[fidx_reg];
		else
			pix = bar_byte;
	end

	// frame sequencer; one line slot per line period
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg     <= CTPG_IDLE;
			line_reg   <= 16'h0000;
			byte_reg   <= 16'h0000;
			barpos_reg <= 16'h0000;
			bar_reg    <= 3'h0;
			fidx_reg   <= 4'h0;
			pd_cnt_reg <= 16'h0000;
			fe_reg     <= 1'b0;
		end else begin
			// period counter restarts every line slot
			if (pd_cnt_reg >= 16'(pd_reg * PD_DIV) - 16'h0001 || st_reg == CTPG_IDLE)
				pd_cnt_reg <= 16'h0000;
			else
				pd_cnt_reg <= pd_cnt_reg + 16'h0001;
			case (st_reg)
				CTPG_IDLE: begin
					line_reg <= 16'h0000;
					fe_reg   <= 1'b0;
					if (en)
						st_reg <= CTPG_SHORT;
				end
				CTPG_SHORT: begin
					if (tx_ready) begin
						if (fe_reg)
							st_reg <= CTPG_WAIT;
						else if (line_reg >= 16'(vbp_reg) &&
							line_reg < 16'(vbp_reg) + act_reg)
							st_reg <= CTPG_HDR;
						else
							st_reg <= CTPG_WAIT;
					end
				end
				CTPG_HDR: begin
					byte_reg   <= 16'h0000;
					barpos_reg <= 16'h0000;
					bar_reg    <= 3'h0;
					fidx_reg   <= 4'h0;
					if (tx_ready)
						st_reg <= (lsize_reg == 16'h0000) ? CTPG_WAIT : CTPG_DATA;
				end
				CTPG_DATA: begin
					if (tx_ready) begin
						byte_reg <= byte_reg + 16'h0001;
						fidx_reg <= (5'(fidx_reg) + 5'h01 >= fblk_reg) ? 4'h0 : fidx_reg + 4'h1;
						// advance bars; last bar runs to line end
						if (barpos_reg + 16'h0001 >= bsize_reg && bar_reg != bar_last) begin
							barpos_reg <= 16'h0000;
							bar_reg    <= bar_reg + 3'h1;
						end else
							barpos_reg <= barpos_reg + 16'h0001;
						if (byte_reg + 16'h0001 >= lsize_reg)
							st_reg <= CTPG_WAIT;
					end
				end
				CTPG_WAIT: begin
					if (pd_cnt_reg >= 16'(pd_reg * PD_DIV) - 16'h0001 || pd_reg == 16'h0000) begin
						line_reg <= line_reg + 16'h0001;
						// after frame end, blank slots pad the frame to the total
						if (!en || (fe_reg && line_reg + 16'h0001 >= tot_reg)) begin
							st_reg <= CTPG_IDLE;
							fe_reg <= 1'b0;
						end else if (fe_reg)
							st_reg <= CTPG_WAIT;
						else if (line_reg + 16'h0001 ==
							16'(vbp_reg) + act_reg + 16'(vfp_reg)) begin
							fe_reg <= 1'b1;
							st_reg <= CTPG_SHORT;
						end else
							st_reg <= (line_reg + 16'h0001 >= 16'(vbp_reg) &&
								line_reg + 16'h0001 < 16'(vbp_reg) + act_reg) ?
								CTPG_HDR : CTPG_WAIT;
					end
				end
				default: st_reg <= CTPG_IDLE;
			endcase
		end
	end

	// transmitter outputs
	always_comb begin
		tx_sop   = (st_reg == CTPG_SHORT) || (st_reg == CTPG_HDR);
		tx_short = (st_reg == CTPG_SHORT);
		tx_valid = (st_reg == CTPG_DATA);
		tx_eop   = (st_reg == CTPG_DATA) && (byte_reg + 16'h0001 >= lsize_reg);
	end

	// packet header fields and data byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_di   <= 8'h00;
			tx_wc   <= 16'h0000;
			tx_data <= 8'h00;
		end else begin
			// fields are registered from the header held in this cycle and appear one cycle later, stable while stalled
			if (st_reg == CTPG_SHORT)
				tx_di <= {di_reg[7:6], fe_reg ? `CTPG_DT_FE : `CTPG_DT_FS};
			else
				tx_di <= di_reg;
			tx_wc   <= (st_reg == CTPG_SHORT) ? 16'h0000 : lsize_reg;
			tx_data <= pix;
		end
	end
endmodule : ctpg_top
`default_nettype wire

//--- dv/ctpg_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctpg_consts.svh"
module ctpg_chk #(
	parameter int NBYTE = 16
) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        tx_sop,
	input wire logic        tx_short,
	input wire logic [7:0]  tx_di,
	input wire logic [15:0] tx_wc,
	input wire logic        tx_valid,
	input wire logic        tx_eop,
	input wire logic        tx_ready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// short header taken by the transmitter
	sequence short_took;
		tx_sop && tx_short && tx_ready;
	endsequence
	// stalled header
	sequence hdr_stall;
		tx_sop && !tx_ready;
	endsequence
	AST_RD_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data without a read");
	AST_HDR_DATA: assert property (!(tx_sop && tx_valid))
		else $error("header and byte together");
	AST_EOP_IN: assert property (tx_eop |-> tx_valid)
		else $error("last flag without byte");
	AST_SHORT_HDR: assert property (tx_short |-> tx_sop)
		else $error("short flag without header");
	AST_SOP_HOLD: assert property (hdr_stall |=> tx_sop && $stable(tx_short))
		else $error("header dropped while stalled");
	AST_BYTE_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid)
		else $error("byte dropped while stalled");
	AST_SHORT_WC: assert property (short_took |=> tx_wc == 16'h0000)
		else $error("short packet with word count");
	AST_SHORT_DT: assert property (short_took |=> tx_di[5:0] inside {`CTPG_DT_FS, `CTPG_DT_FE})
		else $error("short packet with wrong code");
	AST_EOP_GAP: assert property (tx_eop && tx_ready |=> !tx_valid)
		else $error("byte right after line end");
endmodule : ctpg_chk
bind ctpg_top ctpg_chk #(.NBYTE(NBYTE)) u_chk (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tx_sop(tx_sop), .tx_short(tx_short), .tx_di(tx_di), .tx_wc(tx_wc),
	.tx_valid(tx_valid), .tx_eop(tx_eop), .tx_ready(tx_ready));
`default_nettype wire

//--- dv/ctpg_tx_model.sv
`timescale 1ns/1ns
`default_nettype none
module ctpg_tx_model (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        slow,
	input wire logic        tx_sop,
	input wire logic        tx_short,
	input wire logic [7:0]  tx_di,
	input wire logic [15:0] tx_wc,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	output logic            tx_ready
);
	logic [24:0] hq[$];
	logic [7:0]  dq[$];
	int          tq[$];
	int          cyc;
	bit          tog;
	logic        hp, sh, dp;
	// ready always, or every other cycle when slow
	assign tx_ready = !slow || tog;
	always_ff @(posedge clk) begin
		tog <= !tog;
		cyc <= cyc + 1;
	end
	// fields land one cycle after the take
	always_ff @(posedge clk) begin
		hp <= tx_sop && tx_ready && !sys_rst;
		sh <= tx_short;
		dp <= tx_valid && tx_ready && !sys_rst;
		if (hp) begin
			hq.push_back({sh, tx_di, tx_wc});
			tq.push_back(cyc);
		end
		if (dp)
			dq.push_back(tx_data);
	end
endmodule : ctpg_tx_model
`default_nettype wire

//--- dv/ctpg_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctpg_consts.svh"
module ctpg_top_tb;
	logic        clk, sys_rst, reg_wr, reg_rd, slow, tx_ready;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, tx_di, tx_data;
	logic [15:0] tx_wc;
	logic        tx_sop, tx_short, tx_valid, tx_eop;
	logic [7:0]  bt[8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80};
	logic [7:0]  fx[16];
	int          failures, samples_checked, cyc, fb, lp;
	ctpg_top #(.NBYTE(16)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_sop(tx_sop), .tx_short(tx_short), .tx_di(tx_di), .tx_wc(tx_wc),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_eop(tx_eop), .tx_ready(tx_ready));
	ctpg_tx_model p (.clk(clk), .sys_rst(sys_rst), .slow(slow), .tx_sop(tx_sop),
		.tx_short(tx_short), .tx_di(tx_di), .tx_wc(tx_wc), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			final_report();
		end
	end
	task final_report();
		$display("checked %0d, bad %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task chk(input logic [24:0] s, e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 8'h01, v[7:0]);
	endtask : wr16
	task rd(input logic [7:0] a, e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge clk);
	endtask : rd
	// expected byte i of a line
	function logic [7:0] eb(input int i, n, f);
		int b;
		b = i / 3;
		if (b > n - 1)
			b = n - 1;
		return f ? fx[i % fb] ^ {8{b[0]}} : bt[(b + 1) * (8 / n) - 1];
	endfunction : eb
	// one frame: headers, spacing, bytes
	task frame(input int n, f);
		p.hq.delete();
		p.dq.delete();
		p.tq.delete();
		wr(`CTPG_ADDR_CTL, 8'h01);
		while (p.hq.size() < 5)
			@(posedge clk);
		wr(`CTPG_ADDR_CTL, 8'h00);
		chk(p.hq[0], {1'b1, 8'h40, 16'h0000});
		chk(p.hq[1], {1'b0, 8'h64, 16'h001b});
		chk(p.hq[2], {1'b0, 8'h64, 16'h001b});
		chk(p.hq[3], {1'b1, 8'h41, 16'h0000});
		chk(p.hq[4], {1'b1, 8'h40, 16'h0000});
		chk(p.tq[2] - p.tq[1], lp);
		chk(p.tq[1] - p.tq[0] inside {[2 * lp - 1 : 2 * lp + 1]}, 1);
		chk(p.tq[3] - p.tq[2] inside {[2 * lp - 1 : 2 * lp + 1]}, 1);
		chk(p.tq[4] - p.tq[3] inside {[3 * lp : 3 * lp + 2]}, 1);
		if (slow)
			chk(p.dq.size(), 54);
		else
			for (int k = 0; k < 54; k++)
				chk(p.dq[k], eb(k % 27, n, f));
		repeat (400) @(posedge clk);
		$display("end frame bars=%0d fixed=%0d", n, f);
	endtask : frame
	initial begin
		sys_rst = 1;
		reg_wr = 0;
		reg_rd = 0;
		reg_addr = 0;
		reg_wdata = 0;
		slow = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		rd(`CTPG_ADDR_CFG, 8'h30);
		rd(`CTPG_ADDR_DI, 8'h24);
		rd(`CTPG_ADDR_FBLK, 8'h10);
		rd(8'hff, 8'h00);
		$display("end reset values");
		wr(`CTPG_ADDR_DI, 8'h64);
		wr16(`CTPG_ADDR_LSIZE1, 16'h001b);
		wr16(`CTPG_ADDR_BSIZE1, 16'h0003);
		wr16(`CTPG_ADDR_ACT1, 16'h0002);
		wr16(`CTPG_ADDR_TOT1, 16'h0008);
		wr16(`CTPG_ADDR_PD1, 16'h0030);
		lp = 48;
		wr(`CTPG_ADDR_VBP, 8'h02);
		wr(`CTPG_ADDR_VFP, 8'h01);
		rd(`CTPG_ADDR_LSIZE0, 8'h1b);
		frame(8, 0);
		for (int k = 0; k < 3; k++) begin
			wr(`CTPG_ADDR_CFG, 8'(k << 4));
			frame(1 << k, 0);
		end
		fb = 5;
		for (int k = 0; k < 16; k++) begin
			fx[k] = 8'(k * 17 + 3);
			wr(`CTPG_ADDR_FIX0 + 8'(k), fx[k]);
		end
		wr(`CTPG_ADDR_FBLK, 8'h05);
		wr(`CTPG_ADDR_CFG, 8'h90);
		frame(2, 1);
		// a stalled line needs a longer slot than its bytes
		wr16(`CTPG_ADDR_PD1, 16'h0040);
		lp = 64;
		slow <= 1'b1;
		frame(2, 1);
		final_report();
	end
endmodule : ctpg_top_tb
`default_nettype wire
